// *** psm_power_save.v ***
// Power-save controller: Sleep and Idle sequencing, clock gating and module disables.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "psm_map.vh"
module psm_power_save #(
	parameter HAS_CAN = 1
)(
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Avalon-MM register slave
	input wire [`PSM_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Core interface
	input wire power_save_instruction_retire,
	input wire power_save_instruction_idle_sel,
	input wire irq_enabled_pending,
	input wire dev_reset_req,
	input wire wdt_timeout,
	input wire wdt_enable,
	input wire cfm_enable,
	input wire ext_osc_in_use,
	output reg cpu_run,
	output reg resume_pulse,
	output reg irq_deliver,
	// Clock and power controls
	output reg sysclk_run,
	output reg onchip_osc_on,
	output reg cfm_active,
	output reg low_power_rc_clock_run,
	output reg wdt_clear,
	output reg core_reg_standby,
	output reg flash_reg_standby,
	output reg clk_src_restore,
	output reg clk_src_keep,
	// Peripheral clock enables
	output reg adc1_run,
	output reg can1_run,
	output reg can2_run,
	output reg serial1_run,
	output reg serial2_run,
	output reg timer1_run,
	output reg icn_run
);
	localparam [15:0] PMD_MASK = HAS_CAN ? `PSM_PERIPHERAL_DISABLE_1_MASK_CAN :
		`PSM_PERIPHERAL_DISABLE_1_MASK_NOCAN;
	reg [15:0] peripheral_disable_1;
	reg [15:0] reset_control_reg;
	reg [15:0] timer1_control_reg;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [1:0] wake_cnt;
	reg held_irq;
	reg clk_src_saved;
	reg bus_done;
	wire wake_evt;
	wire in_sleep;
	wire in_idle;
	wire idle_stop_t1;
	wire [15:0] status_word;
	wire access;

	assign access = (avs_read | avs_write) & ~bus_done;
	// An enabled interrupt, any reset or a time-out ends both modes.
	assign wake_evt = irq_enabled_pending | dev_reset_req | wdt_timeout |
		held_irq;
	assign in_sleep = (state == `PSM_ST_SLEEP);
	assign in_idle = (state == `PSM_ST_IDLE);
	assign idle_stop_t1 = timer1_control_reg[`PSM_BIT_TIMER_STOP_IN_IDLE];
	assign status_word = {12'h000, in_idle, in_sleep, cpu_run, clk_src_saved};

	// One wait cycle per access keeps the read path registered.
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			peripheral_disable_1 <= 16'h0000;
			reset_control_reg <= 16'h0000;
			timer1_control_reg <= 16'h0000;
			avs_readdata <= 32'h00000000;
			avs_waitrequest <= 1'b1;
			bus_done <= 1'b0;
		end
		else
		begin
			avs_waitrequest <= ~access;
			bus_done <= access;
			// A write lands only at the edge where waitrequest is seen low.
			if (bus_done && avs_write)
			begin
				case (avs_address)
				`PSM_OFF_PERIPHERAL_DISABLE_1:
					peripheral_disable_1 <= avs_writedata[15:0] &
						PMD_MASK;
				`PSM_OFF_RCTL:
					reset_control_reg <= avs_writedata[15:0] &
						`PSM_RCTL_MASK;
				`PSM_OFF_T1CTL:
					timer1_control_reg <= avs_writedata[15:0] &
						`PSM_T1CTL_MASK;
				default:
					reset_control_reg <= reset_control_reg;
				endcase
			end
			if (access && avs_read)
			begin
				case (avs_address)
				`PSM_OFF_PERIPHERAL_DISABLE_1:
					avs_readdata <= {16'h0000, peripheral_disable_1};
				`PSM_OFF_RCTL:
					avs_readdata <= {16'h0000, reset_control_reg};
				`PSM_OFF_T1CTL:
					avs_readdata <= {16'h0000, timer1_control_reg};
				`PSM_OFF_STAT:
					avs_readdata <= {16'h0000, status_word};
				default:
					avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	always @*
	begin
		next_state = state;
		case (state)
		`PSM_ST_RUN:
			if (power_save_instruction_retire && !dev_reset_req)
				next_state = `PSM_ST_ENTER;
		`PSM_ST_ENTER:
			next_state = power_save_instruction_idle_sel ? `PSM_ST_IDLE :
				`PSM_ST_SLEEP;
		`PSM_ST_SLEEP:
			if (wake_evt)
				next_state = `PSM_ST_WAKE;
		`PSM_ST_IDLE:
			if (wake_evt)
				next_state = `PSM_ST_WAKE;
		`PSM_ST_WAKE:
			if (wake_cnt == 2'h0)
				next_state = `PSM_ST_RUN;
		default:
			next_state = `PSM_ST_RUN;
		endcase
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= `PSM_ST_RUN;
			wake_cnt <= 2'h0;
			held_irq <= 1'b0;
			clk_src_saved <= 1'b0;
			cpu_run <= 1'b1;
			resume_pulse <= 1'b0;
			irq_deliver <= 1'b0;
			wdt_clear <= 1'b0;
			clk_src_restore <= 1'b0;
			clk_src_keep <= 1'b0;
		end
		else
		begin
			state <= next_state;
			resume_pulse <= 1'b0;
			irq_deliver <= 1'b0;
			wdt_clear <= 1'b0;
			clk_src_restore <= 1'b0;
			// Interrupts seen during entry are held until the wake state, so they end the mode as soon as it is reached.
			if ((state == `PSM_ST_RUN && power_save_instruction_retire) ||
				state == `PSM_ST_ENTER)
			begin
				if (irq_enabled_pending)
					held_irq <= 1'b1;
			end
			else if (state == `PSM_ST_WAKE)
				held_irq <= 1'b0;
			if (state == `PSM_ST_RUN && power_save_instruction_retire && !dev_reset_req)
			begin
				cpu_run <= 1'b0;
				clk_src_saved <= ext_osc_in_use;
				wdt_clear <= wdt_enable;
			end
			if ((in_sleep || in_idle) && wake_evt)
			begin
				wake_cnt <= `PSM_WAKE_CYC;
				clk_src_restore <= in_sleep;
				irq_deliver <= irq_enabled_pending | held_irq;
			end
			else if (state == `PSM_ST_WAKE && wake_cnt != 2'h0)
				wake_cnt <= wake_cnt - 2'h1;
			if (state == `PSM_ST_WAKE && wake_cnt == 2'h0)
			begin
				cpu_run <= 1'b1;
				resume_pulse <= 1'b1;
			end
			clk_src_keep <= clk_src_saved;
		end
	end

	// Clock, regulator and peripheral controls other than icn_run follow the next state.
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sysclk_run <= 1'b1;
			onchip_osc_on <= 1'b1;
			cfm_active <= 1'b0;
			low_power_rc_clock_run <= 1'b0;
			core_reg_standby <= 1'b0;
			flash_reg_standby <= 1'b0;
			adc1_run <= 1'b1;
			can1_run <= 1'b0;
			can2_run <= 1'b0;
			serial1_run <= 1'b1;
			serial2_run <= 1'b1;
			timer1_run <= 1'b1;
			icn_run <= 1'b1;
		end
		else
		begin
			sysclk_run <= (next_state != `PSM_ST_SLEEP);
			onchip_osc_on <= (next_state != `PSM_ST_SLEEP) &
				~ext_osc_in_use;
			cfm_active <= cfm_enable &
				(next_state != `PSM_ST_SLEEP);
			low_power_rc_clock_run <= (next_state == `PSM_ST_SLEEP) ? wdt_enable :
				(wdt_enable | cfm_enable);
			core_reg_standby <= (next_state == `PSM_ST_SLEEP) &
				~reset_control_reg[`PSM_BIT_CORE_KEEP];
			flash_reg_standby <= (next_state == `PSM_ST_SLEEP) &
				~reset_control_reg[`PSM_BIT_FLASH_KEEP];
			adc1_run <= (next_state != `PSM_ST_SLEEP) &
				~peripheral_disable_1[`PSM_BIT_ADC1];
			can1_run <= (HAS_CAN != 0) & (next_state != `PSM_ST_SLEEP) &
				~peripheral_disable_1[`PSM_BIT_CAN1];
			can2_run <= (HAS_CAN != 0) & (next_state != `PSM_ST_SLEEP) &
				~peripheral_disable_1[`PSM_BIT_CAN2];
			serial1_run <= (next_state != `PSM_ST_SLEEP) &
				~peripheral_disable_1[`PSM_BIT_SPI1];
			serial2_run <= (next_state != `PSM_ST_SLEEP) &
				~peripheral_disable_1[`PSM_BIT_SPI2];
			timer1_run <= (next_state != `PSM_ST_SLEEP) &
				~((next_state == `PSM_ST_IDLE) & idle_stop_t1);
			icn_run <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** psm_map.vh ***
// Register offsets, field positions and timing constants for the power-save controller.
`ifndef PSM_MAP_VH
`define PSM_MAP_VH
`define PSM_ADDR_W 4
`define PSM_OFF_PERIPHERAL_DISABLE_1 4'h0
`define PSM_OFF_RCTL 4'h4
`define PSM_OFF_T1CTL 4'h8
`define PSM_OFF_STAT 4'hC
`define PSM_PERIPHERAL_DISABLE_1_MASK_CAN 16'h001F
`define PSM_PERIPHERAL_DISABLE_1_MASK_NOCAN 16'h0019
`define PSM_BIT_ADC1 0
`define PSM_BIT_CAN1 1
`define PSM_BIT_CAN2 2
`define PSM_BIT_SPI1 3
`define PSM_BIT_SPI2 4
`define PSM_BIT_CORE_KEEP 8
`define PSM_BIT_FLASH_KEEP 11
`define PSM_RCTL_MASK 16'h0900
`define PSM_BIT_TIMER_STOP_IN_IDLE 13
`define PSM_T1CTL_MASK 16'h2000
`define PSM_WAKE_CYC 2'h2
`define PSM_ST_RUN 3'h0
`define PSM_ST_ENTER 3'h1
`define PSM_ST_SLEEP 3'h2
`define PSM_ST_IDLE 3'h3
`define PSM_ST_WAKE 3'h4
`endif

// *** psm_power_save_assertions.sv ***
// Concurrent checks on the power-save controller ports.
`timescale 1ns/1ns
`default_nettype none
module psm_power_save_chk (
	// Clock, reset and bus
	input wire logic mclk, rst_n, avs_read, avs_write, avs_waitrequest,
	// Core side
	input wire logic power_save_instruction_retire, power_save_instruction_idle_sel, irq_enabled_pending,
	input wire logic dev_reset_req, wdt_timeout, wdt_enable, cpu_run,
	// Controls
	input wire logic irq_deliver, sysclk_run, onchip_osc_on, cfm_active,
	input wire logic low_power_rc_clock_run, wdt_clear, core_reg_standby,
	input wire logic resume_pulse, clk_src_restore
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence take_s;
		power_save_instruction_retire && cpu_run && !dev_reset_req;
	endsequence
	sequence quiet_s;
		!irq_enabled_pending && !wdt_timeout && !power_save_instruction_idle_sel;
	endsequence
	bus_answer_a:
		assert property ((avs_read || avs_write) && avs_waitrequest
			|=> !avs_waitrequest) else $error("bus answer late");
	bus_short_a:
		assert property (!avs_waitrequest |=> avs_waitrequest)
			else $error("bus answer too long");
	cpu_halt_a:
		assert property (take_s |=> !cpu_run) else $error("cpu not halted");
	wdt_clear_a:
		assert property (take_s ##0 wdt_enable |=> wdt_clear)
			else $error("watchdog not cleared");
	sleep_stop_a:
		assert property (take_s ##0 quiet_s |-> ##[1:2] !sysclk_run)
			else $error("sleep clock still runs");
	idle_clk_a:
		assert property (take_s ##0 power_save_instruction_idle_sel |=> sysclk_run[*3])
			else $error("idle clock stopped");
	sleep_osc_a:
		assert property (!sysclk_run |-> !onchip_osc_on && !cfm_active)
			else $error("oscillator or monitor on in sleep");
	rc_keep_a:
		assert property (!sysclk_run && !$past(sysclk_run) && wdt_enable
			&& $past(wdt_enable) |-> low_power_rc_clock_run) else $error("rc clock off");
	standby_a:
		assert property (core_reg_standby |-> !sysclk_run)
			else $error("standby outside sleep");
	wake_resume_a:
		assert property (irq_deliver |-> !cpu_run ##[1:4] cpu_run)
			else $error("resume late");
	resume_mark_a:
		assert property ($rose(cpu_run) |-> resume_pulse)
			else $error("resume pulse missing");
	src_restore_a:
		assert property (irq_deliver && !$past(sysclk_run)
			|-> clk_src_restore) else $error("clock source not restored");
endmodule
bind psm_power_save psm_power_save_chk i_chk (.*);
`default_nettype wire

// *** psm_power_save_tb.sv ***
// Testbench for the power-save controller.
`timescale 1ns/1ns
`default_nettype none
module psm_power_save_tb;
	logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, power_save_instruction_retire = 0, power_save_instruction_idle_sel = 0;
	logic irq_enabled_pending = 0, dev_reset_req = 0, wdt_timeout = 0;
	logic wdt_enable = 1, cfm_enable = 0, ext_osc_in_use = 0;
	logic cpu_run, resume_pulse, irq_deliver, sysclk_run, onchip_osc_on;
	logic cfm_active, low_power_rc_clock_run, wdt_clear, core_reg_standby;
	logic flash_reg_standby, clk_src_restore, clk_src_keep, adc1_run;
	logic can1_run, can2_run, serial1_run, serial2_run, timer1_run, icn_run;
	int errors = 0, check_count = 0;
	psm_power_save i_dut (.*);
	initial forever #4 mclk = ~mclk;
	task chk(input string n, input logic [31:0] e, s);
		check_count++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// The request stands until waitrequest is sampled low.
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0 && ++n < 50);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (n >= 50) errors++;
		@(posedge mclk);
	endtask
	task pwr(input logic idle);
		power_save_instruction_retire <= 1;
		power_save_instruction_idle_sel <= idle;
		@(posedge mclk);
		power_save_instruction_retire <= 0;
		@(posedge mclk);
		power_save_instruction_idle_sel <= 0;
		repeat (2) @(posedge mclk);
	endtask
	task wake(input logic [1:0] m);
		int n;
		n = 0;
		{wdt_timeout, irq_enabled_pending} <= m;
		while (cpu_run !== 1'b1 && n < 20)
		begin
			@(posedge mclk);
			n++;
		end
		{wdt_timeout, irq_enabled_pending} <= 2'h0;
		chk("wake_cycles", 1, n > 1 && n < 8);
		chk("clk_back", 1, sysclk_run);
		@(posedge mclk);
	endtask
	task stop_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#20000;
		errors++;
		stop_test;
	end
	initial
	begin
		repeat (16) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		bus(0, 4'h0, 0);
		chk("disable_rst", 0, rd);
		chk("can1_run", 1, can1_run);
		bus(1, 4'h0, 32'hFFFF);
		bus(0, 4'h0, 0);
		chk("disable_rw", 32'h1F, rd);
		for (int i = 0; i < 5; i++)
		begin
			bus(1, 4'h0, 32'h1 << i);
			@(posedge mclk);
			chk("run_bits", ~(32'h1 << i) & 32'h1F, {serial2_run, serial1_run,
				can2_run, can1_run, adc1_run});
		end
		bus(1, 4'h0, 0);
		bus(0, 4'h2, 0);
		chk("unmapped", 0, rd);
		pwr(0);
		chk("sleep_ctl", 32'h1E, {cpu_run, sysclk_run, onchip_osc_on,
			cfm_active, low_power_rc_clock_run, core_reg_standby, flash_reg_standby,
			icn_run, adc1_run});
		bus(0, 4'hC, 0);
		chk("status_sleep", 32'h4, rd);
		wake(2'h1);
		bus(1, 4'h4, 32'hFFFF);
		bus(0, 4'h4, 0);
		chk("keep_rw", 32'h0900, rd);
		ext_osc_in_use <= 1;
		pwr(0);
		chk("keep_on", 0, {core_reg_standby, flash_reg_standby});
		chk("src_keep", 1, clk_src_keep);
		bus(0, 4'hC, 0);
		chk("status_src", 32'h5, rd);
		wake(2'h2);
		ext_osc_in_use <= 0;
		bus(1, 4'h8, 32'hFFFF);
		bus(0, 4'h8, 0);
		chk("tstop_rw", 32'h2000, rd);
		wdt_enable <= 0;
		cfm_enable <= 1;
		pwr(1);
		chk("idle_ctl", 32'hB, {cpu_run, sysclk_run, timer1_run, adc1_run,
			low_power_rc_clock_run});
		wake(2'h2);
		wdt_enable <= 1;
		irq_enabled_pending <= 1;
		fork
			pwr(1);
			begin
				@(posedge mclk);
				irq_enabled_pending <= 0;
			end
		join
		wake(2'h0);
		stop_test;
	end
endmodule
`default_nettype wire
